//--- common/rst_seq_defs.svh
// Constants for the reset sequencer: offsets, reset values, timings
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH

// Number of byte registers that take a reset value
`define NREG 57
// Register index per slot, slot 0 first (byte address is index times 4)
`define IDX_TAB {16'h0000, 16'h0002, 16'h0003, 16'h0004, 16'h0005, \
  16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c, \
  16'h000d, 16'h000e, 16'h000f, 16'h0018, 16'h0019, 16'h0016, 16'h0017, \
  16'h0014, 16'h0015, 16'h001a, 16'h001b, 16'h001c, 16'h001d, 16'h0027, \
  16'h0028, 16'h0029, 16'h002c, 16'h002d, 16'h002e, 16'h002f, 16'h0080, \
  16'h0081, 16'h0040, 16'h0041, 16'h0042, 16'h0043, 16'h0044, 16'h0045, \
  16'h0046, 16'h0047, 16'h0048, 16'h0049, 16'h004a, 16'h004c, 16'h004d, \
  16'h004e, 16'h0054, 16'h0082, 16'h006c, 16'h006d, 16'h006e, 16'h006f, \
  16'h0083, 16'hffc9, 16'h0084}
// Reset value per slot, same order
`define RST_TAB {8'h0c, {6{8'h00}}, {18{8'h00}}, {3{8'h00}}, 8'h18, \
  8'hff, 8'hff, 8'h00, 8'h80, 8'h80, {8{8'h00}}, {6{8'h00}}, 8'hff, \
  8'h33, 8'h60, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'h04}
// Slots with special meaning
`define SLOT_CPU_MODE_A 7'd0
`define SLOT_PORT_BASE 7'd7
`define SLOT_FLASH_CTL 7'd54
`define SLOT_CODE_PROT 7'd55
`define SLOT_STATUS_PS 7'd56
`define SLOT_NONE 7'd127
// Read-only views of the sequencer itself
`define IDX_STAB_ONE 16'h0024
`define IDX_STAB_TWO 16'h0025
`define IDX_SEQ_STATUS 16'h0085
// Stabilisation timer preloads and prescale
`define STAB_ONE_PRESET 8'hff
`define STAB_TWO_PRESET 8'h01
`define PRESC_LAST 3'd7
// Start vector locations
`define VEC_HI_ADDR 16'hfffa
`define VEC_LO_ADDR 16'hfffb
// Pin directions during reset, 1 = output
`define DIR_ALL_OUT 8'hff
`define DIR_ALL_IN 8'h00
`define DIR_P3_RST 8'hf8
`define NPORT 9

`endif

//--- common/rst_seq_pkg.sv
// Types shared by the reset sequencer and its stabilisation timer
`include "rst_seq_defs.svh"
package rst_seq_pkg;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_OSC_WAIT,
    ST_VEC_HI,
    ST_VEC_LO,
    ST_RUN
  } seq_state_e;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    byte_t count;
  } timer_s;

  typedef struct packed {
    logic [1:0]               pin_sync;
    seq_state_e               state;
    logic                     strap;
    logic [2:0]               presc;
    byte_t [`NREG-1:0]        regs;
    logic [15:0]              pc;
    logic                     vec_req;
    logic [15:0]              vec_addr;
    logic                     phi_hold;
    logic                     core_run;
    byte_t [`NPORT-1:0]       pin_dir;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } seq_s;

endpackage

//--- rtl/stab_timer.sv
// Eight-bit down-counting stabilisation timer with reload latch
`timescale 1ns/1ps
module stab_timer
(
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  // Control
  input  wire logic                 load_i,
  input  wire rst_seq_pkg::byte_t   preset_i,
  input  wire logic                 tick_i,
  // Status
  output rst_seq_pkg::byte_t        count_o,
  output logic                      underflow_o
);
  import rst_seq_pkg::*;

  timer_s s;
  timer_s next_s;

  // Underflow at the tick after reaching zero, so ratio is n+1
  assign underflow_o = tick_i && (s.count == 8'h00);
  assign count_o     = s.count;

  // Load wins over counting; underflow reloads the preset
  always_comb
  begin
    next_s = s;
    if (load_i || underflow_o)
      next_s.count = preset_i;
    else if (tick_i)
      next_s.count = s.count - 8'h01;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      s <= '{count: `STAB_ONE_PRESET};
    else
      s <= next_s;
  end
endmodule

//--- rtl/mcu_reset_sequencer.sv
// Reset sequencer: pin reset, clock settle wait, vector fetch, reset values
//
// What this block does
// - Start address fetched high byte, then low byte
// - Settle timers preloaded FF and 01 on restart
// - Core clock held high until timer two underflows
// - Strap selects output ports during reset, else inputs
// - CPU mode register A resets to 0c
// - Interrupt request and control registers reset clear
// - Port data and direction registers reset clear
// - Timer X, Y and 1/2/3 modes reset clear
// - Count source timers FF, their mode clear
// - Synthesizer control 60, multiply and divide FF
// - USB interrupt enables reset to FF and 33
// - Serial I/O control two resets to 18
// - Each UART RTS control resets to 80
// - Host buffer data, status, control reset clear
// - DMA mode, address and count registers reset clear
// - Processor status bit two set at reset
// - Flash-only registers; code protect resets to FF
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module mcu_reset_sequencer
#(
  parameter bit FLASH_VARIANT = 1'b1
)
(
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  // Device pins
  input  wire logic                 reset_n_i,
  input  wire logic                 processor_mode_strap_i,
  output rst_seq_pkg::byte_t [8:0]  pin_dir_o,
  // Start vector fetch
  output logic                      vec_req_o,
  output logic [15:0]               vec_addr_o,
  input  wire rst_seq_pkg::byte_t   vec_data_i,
  input  wire logic                 vec_ack_i,
  // Core side
  output logic [15:0]               pc_o,
  output logic                      phi_hold_o,
  output logic                      core_run_o,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [17:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o
);
  import rst_seq_pkg::*;

  localparam logic [`NREG*16-1:0] IDX_TABLE = `IDX_TAB;
  localparam logic [`NREG*8-1:0]  RST_TABLE = `RST_TAB;

  seq_s s;
  seq_s next_s;

  logic   in_rst;
  logic   t1_tick;
  logic   t1_uf;
  logic   t2_uf;
  byte_t  t1_cnt;
  byte_t  t2_cnt;
  logic   acc_phase;
  logic   done_wr;
  logic [6:0]  slot;
  logic [15:0] idx;

  // Slot that holds a register index, SLOT_NONE when unmapped
  function automatic logic [6:0] find_slot(input logic [15:0] ix);
    logic [6:0] r;
    r = `SLOT_NONE;
    for (int i = 0; i < `NREG; i++)
      if (IDX_TABLE[(`NREG-1-i)*16 +: 16] == ix)
        r = 7'(i);
    // Flash-only registers vanish in the mask variant
    if (!FLASH_VARIANT &&
        (r == `SLOT_FLASH_CTL || r == `SLOT_CODE_PROT))
      r = `SLOT_NONE;
    return r;
  endfunction

  // Documented reset value of one slot
  function automatic byte_t rst_val(input int i);
    return RST_TABLE[(`NREG-1-i)*8 +: 8];
  endfunction

  // Whole reset picture in slot order; the table runs slot 0 first
  function automatic logic [`NREG*8-1:0] rst_image();
    logic [`NREG*8-1:0] img;
    for (int i = 0; i < `NREG; i++)
      img[i*8 +: 8] = rst_val(i);
    return img;
  endfunction

  // Internal reset follows the synchronised pin, low active
  // The pin must stay low twenty phi cycles for a clean load
  assign in_rst = s.pin_sync[1] == 1'b0;

  // Timer one counts phi/8, timer two counts timer one underflows
  assign t1_tick = (s.state == ST_OSC_WAIT) && (s.presc == `PRESC_LAST);

  // Stabilisation timer one, preset FF while in reset
  stab_timer u_stab_one
  (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .load_i      (in_rst),
    .preset_i    (`STAB_ONE_PRESET),
    .tick_i      (t1_tick),
    .count_o     (t1_cnt),
    .underflow_o (t1_uf)
  );

  // Stabilisation timer two, preset 01 while in reset
  stab_timer u_stab_two
  (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .load_i      (in_rst),
    .preset_i    (`STAB_TWO_PRESET),
    .tick_i      (t1_uf),
    .count_o     (t2_cnt),
    .underflow_o (t2_uf)
  );

  // APB decode; one wait state keeps all answers registered
  assign acc_phase = psel_i && penable_i && !s.pready;
  assign idx       = paddr_i[17:2];
  assign slot      = find_slot(idx);
  assign done_wr   = psel_i && penable_i && s.pready && pwrite_i &&
                     !s.pslverr;

  // Next state of the whole sequencer
  always_comb
  begin
    next_s = s;
    // Two-flop synchroniser for the reset pin
    next_s.pin_sync = {s.pin_sync[0], reset_n_i};
    next_s.pready   = acc_phase;
    next_s.pslverr  = 1'b0;
    next_s.prdata   = 32'h0000_0000;

    // Bus answer; writes only once the core runs
    if (acc_phase)
    begin
      if (paddr_i[1:0] != 2'b00)
        next_s.pslverr = 1'b1;
      else if (idx == `IDX_STAB_ONE || idx == `IDX_STAB_TWO ||
               idx == `IDX_SEQ_STATUS)
      begin
        next_s.pslverr = pwrite_i;
        if (idx == `IDX_STAB_ONE)
          next_s.prdata = {24'h00_0000, t1_cnt};
        else if (idx == `IDX_STAB_TWO)
          next_s.prdata = {24'h00_0000, t2_cnt};
        else
          next_s.prdata = {24'h00_0000, s.core_run, s.phi_hold,
                           s.strap, 2'b00, s.state};
      end
      else if (slot == `SLOT_NONE)
        next_s.pslverr = 1'b1;
      else
      begin
        next_s.pslverr = pwrite_i &&
                         (s.state != ST_RUN || slot == `SLOT_STATUS_PS);
        next_s.prdata  = {24'h00_0000, s.regs[slot]};
      end
    end
    if (done_wr && slot != `SLOT_NONE)
      next_s.regs[slot] = pwdata_i[7:0];

    // Sequence control
    unique case (s.state)
      ST_HOLD:
      begin
        next_s.strap = processor_mode_strap_i;
        if (!in_rst)
          next_s.state = ST_OSC_WAIT;
      end
      ST_OSC_WAIT:
      begin
        next_s.presc = s.presc + 3'd1;
        // Only timer two underflow lets phi reach the core
        if (t2_uf)
        begin
          next_s.state    = ST_VEC_HI;
          next_s.phi_hold = 1'b0;
          next_s.vec_req  = 1'b1;
          next_s.vec_addr = `VEC_HI_ADDR;
        end
      end
      ST_VEC_HI:
        if (vec_ack_i)
        begin
          // High-order byte of the start address
          next_s.pc[15:8] = vec_data_i;
          next_s.vec_addr = `VEC_LO_ADDR;
          next_s.state    = ST_VEC_LO;
        end
      ST_VEC_LO:
        if (vec_ack_i)
        begin
          // Low-order byte, then the core starts there
          next_s.pc[7:0]  = vec_data_i;
          next_s.vec_req  = 1'b0;
          next_s.core_run = 1'b1;
          next_s.state    = ST_RUN;
        end
      ST_RUN:
        next_s.state = ST_RUN;
    endcase

    // Pin directions: strap pattern until the core runs
    for (int p = 0; p < `NPORT; p++)
      next_s.pin_dir[p] = s.regs[int'(`SLOT_PORT_BASE) + 2*p + 1];
    if (s.state != ST_RUN)
    begin
      for (int p = 0; p < `NPORT; p++)
        next_s.pin_dir[p] = `DIR_ALL_IN;
      if (s.strap)
      begin
        next_s.pin_dir[0] = `DIR_ALL_OUT;
        next_s.pin_dir[1] = `DIR_ALL_OUT;
        next_s.pin_dir[3] = `DIR_P3_RST;
      end
    end

    // Reset pin low: restart state, prescaler, clock hold and fetch (pc keeps its value), load reset values
    if (in_rst)
    begin
      next_s.state    = ST_HOLD;
      next_s.presc    = 3'd0;
      next_s.phi_hold = 1'b1;
      next_s.core_run = 1'b0;
      next_s.vec_req  = 1'b0;
      next_s.vec_addr = `VEC_HI_ADDR;
      // Table holds all listed values
      // Further listed values
      // Status bit two and flash values
      next_s.regs     = rst_image();
      // Strap follows the pin for the whole reset, never stale
      next_s.strap    = processor_mode_strap_i;
    end
  end

  // Single state register; srst forces the pin-held-low picture
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s          <= '0;
      s.state    <= ST_HOLD;
      s.phi_hold <= 1'b1;
      s.vec_addr <= `VEC_HI_ADDR;
      s.regs     <= rst_image();
    end
    else
      s <= next_s;
  end

  // Outputs straight from the state register
  assign pin_dir_o  = s.pin_dir;
  assign vec_req_o  = s.vec_req;
  assign vec_addr_o = s.vec_addr;
  assign pc_o       = s.pc;
  assign phi_hold_o = s.phi_hold;
  assign core_run_o = s.core_run;
  assign prdata_o   = s.prdata;
  assign pready_o   = s.pready;
  assign pslverr_o  = s.pslverr;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence release_seq;
    s.state == ST_HOLD ##1 s.state == ST_OSC_WAIT;
  endsequence

  a_timer_preload: assert property (
    release_seq |-> t1_cnt == `STAB_ONE_PRESET &&
                    t2_cnt == `STAB_TWO_PRESET)
    else $error("timers not preloaded at release");

  a_phi_held: assert property (
    s.state == ST_OSC_WAIT && !t2_uf |=> phi_hold_o)
    else $error("phi released before timer two underflow");

  a_phi_start: assert property (
    s.state == ST_OSC_WAIT && t2_uf && !in_rst
      |=> !phi_hold_o && vec_req_o && vec_addr_o == `VEC_HI_ADDR)
    else $error("underflow did not start clock and fetch");

  a_vec_lo_pc: assert property (
    s.state == ST_VEC_LO && vec_ack_i && !in_rst
      |=> pc_o[7:0] == $past(vec_data_i) && core_run_o && !vec_req_o)
    else $error("low vector byte not loaded");

  a_vec_hi_pc: assert property (
    s.state == ST_VEC_HI && vec_ack_i && !in_rst
      |=> pc_o[15:8] == $past(vec_data_i) && vec_addr_o == `VEC_LO_ADDR)
    else $error("high vector byte not loaded");

  a_strap_dirs: assert property (
    s.state == ST_HOLD && s.strap |=> pin_dir_o[0] == `DIR_ALL_OUT &&
                                     pin_dir_o[3] == `DIR_P3_RST &&
                                     pin_dir_o[2] == `DIR_ALL_IN)
    else $error("reset pin directions wrong with strap high");

  a_nostrap_dirs: assert property (
    s.state == ST_HOLD && !s.strap |=> pin_dir_o == '0)
    else $error("pins not all inputs with strap low");

  a_reset_values: assert property (
    in_rst |=> s.regs == rst_image() &&
              s.regs[`SLOT_CPU_MODE_A] == 8'h0c)
    else $error("reset values not loaded");

  a_status_bit: assert property (
    in_rst |=> s.regs[`SLOT_STATUS_PS][2])
    else $error("status bit two not set at reset");

  a_sync_delay: assert property (
    $fell(reset_n_i) |-> ##2 in_rst)
    else $error("reset pin not seen after two flops");

  a_apb_answer: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb answer not one wait state");

endmodule

//--- bench/reset_circuit_model.sv
// External reset circuit model driving the device reset pin
`timescale 1ns/1ps
module reset_circuit_model
#(
  parameter int LOW_CYCLES = 20
)
(
  // Clock
  input  wire logic sys_clk_i,
  // Request from the bench, level
  input  wire logic start_i,
  // Device reset pin, active low
  output logic      reset_n_o
);
  int remain = LOW_CYCLES;

  // Low from power-up; a request always restarts the full low time
  always @(posedge sys_clk_i)
  begin
    if (start_i)
      remain <= LOW_CYCLES;
    else if (remain > 0)
      remain <= remain - 1;
  end

  // Never released early, so short pulses cannot come from this side
  assign reset_n_o = (remain == 0);
endmodule

//--- bench/mcu_reset_sequencer_tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module mcu_reset_sequencer_tb_top;
  import rst_seq_pkg::*;

  typedef struct { logic [15:0] idx; byte_t val; } row_s;

  // Bench signals
  logic        sys_clk, srst, reset_n, strap, start, vec_ack, vec_req;
  logic        psel, penable, pwrite, pready, pslverr, phi_hold, core_run;
  logic        err;
  byte_t       vec_data;
  byte_t [8:0] pin_dir;
  logic [15:0] vec_addr, pc;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count, num_checks, n;
  row_s        rows[$];

  // Device under test
  mcu_reset_sequencer mcu_reset_sequencer_i (
    .sys_clk_i(sys_clk), .srst_i(srst), .reset_n_i(reset_n),
    .processor_mode_strap_i(strap), .pin_dir_o(pin_dir),
    .vec_req_o(vec_req), .vec_addr_o(vec_addr), .vec_data_i(vec_data),
    .vec_ack_i(vec_ack), .pc_o(pc), .phi_hold_o(phi_hold),
    .core_run_o(core_run), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  // Reset source on the far side
  reset_circuit_model reset_circuit_model_i (
    .sys_clk_i(sys_clk), .start_i(start), .reset_n_o(reset_n));

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Verdict, the only exit
  task automatic final_report();
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  // One APB transfer; the leading edge keeps back-to-back calls race free
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    check(k < 20, "no ready");
    if (k >= 20)
      final_report();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input byte_t exp);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    check(rd === {24'h0, exp} && err === 1'b0, "read value");
  endtask

  task automatic wr_chk(input logic [15:0] idx, input logic [31:0] d,
                        input logic exp_err);
    apb(1'b1, {idx, 2'b00}, d);
    check(err === exp_err, "write response");
  endtask

  task automatic add(input logic [15:0] first, input int cnt,
                     input byte_t v);
    for (int i = 0; i < cnt; i++)
      rows.push_back('{first + 16'(i), v});
  endtask

  // Main sequence
  initial
  begin
    srst = 1'b1; start = 1'b1; strap = 1'b1; vec_ack = 1'b0;
    vec_data = 8'h00; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 18'h0; pwdata = 32'h0; bad_count = 0; num_checks = 0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check(phi_hold === 1'b1 && core_run === 1'b0 && vec_req === 1'b0,
          "held state");
    check(pin_dir === {{5{8'h00}}, 8'hf8, 8'h00, 8'hff, 8'hff},
          "strap high dirs");
    wr_chk(16'h0000, 32'hff, 1'b1);
    // Reset value rows, read while the pin still holds reset
    add(16'h0000, 1, 8'h0c);
    add(16'h0002, 6, 8'h00);
    add(16'h0008, 8, 8'h00);
    add(16'h0014, 10, 8'h00);
    add(16'h0027, 3, 8'h00);
    add(16'h0024, 1, 8'hff);
    add(16'h0025, 1, 8'h01);
    add(16'h002d, 2, 8'hff);
    add(16'h002f, 1, 8'h00);
    add(16'h006c, 1, 8'h60);
    add(16'h006d, 3, 8'hff);
    add(16'h0054, 1, 8'hff);
    add(16'h0082, 1, 8'h33);
    add(16'h002c, 1, 8'h18);
    add(16'h0080, 2, 8'h80);
    add(16'h0048, 3, 8'h00);
    add(16'h004c, 3, 8'h00);
    add(16'h0040, 8, 8'h00);
    add(16'h0084, 1, 8'h04);
    add(16'hffc9, 1, 8'hff);
    foreach (rows[i])
      rd_chk(rows[i].idx, rows[i].val);
    // Release the pin, then time the settle wait
    start <= 1'b0;
    n = 0;
    while (reset_n !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    check(reset_n === 1'b1, "pin not released");
    if (reset_n !== 1'b1)
      final_report();
    n = 0;
    while (vec_req !== 1'b1 && n < 5000)
    begin
      @(posedge sys_clk);
      n++;
      check(phi_hold === !vec_req, "clock released early");
    end
    check(n >= 4090 && n <= 4130, "settle wait length");
    if (n >= 5000)
      final_report();
    // Start vector fetch, one-cycle acks with an idle cycle between
    check(vec_addr === 16'hfffa && phi_hold === 1'b0, "high fetch");
    vec_ack  <= 1'b1;
    vec_data <= 8'h12;
    @(posedge sys_clk);
    vec_ack <= 1'b0;
    @(posedge sys_clk);
    check(vec_addr === 16'hfffb && pc[15:8] === 8'h12, "low fetch");
    vec_ack  <= 1'b1;
    vec_data <= 8'h34;
    @(posedge sys_clk);
    vec_ack <= 1'b0;
    @(posedge sys_clk);
    check(pc === 16'h1234 && core_run === 1'b1 && vec_req === 1'b0,
          "start vector");
    // Software sets up its own port direction
    wr_chk(16'h0009, 32'ha5, 1'b0);
    rd_chk(16'h0009, 8'ha5);
    repeat (2) @(posedge sys_clk);
    check(pin_dir[0] === 8'ha5, "port0 direction");
    // Refused accesses
    wr_chk(16'h0084, 32'h0, 1'b1);
    wr_chk(16'h0024, 32'h0, 1'b1);
    apb(1'b0, 18'h00004, 32'h0);
    check(err === 1'b1, "unmapped read");
    apb(1'b0, 18'h00002, 32'h0);
    check(err === 1'b1, "misaligned read");
    // Second pin reset, strap low
    strap <= 1'b0;
    start <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(pin_dir === '0 && core_run === 1'b0 && phi_hold === 1'b1,
          "strap low reset");
    rd_chk(16'h0009, 8'h00);
    rd_chk(16'h0000, 8'h0c);
    final_report();
  end
endmodule
